// File: apo_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types of the pixel output and interface select block.
package apo_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register addresses on the plain register port.
	localparam logic [7:0] APO_ADDR_HS_POL = 8'h04; // Sync output polarity.
	localparam logic [7:0] APO_ADDR_HS_WIDTH = 8'h07; // Sync output width in pixel clocks.
	localparam logic [7:0] APO_ADDR_DETECT = 8'h11; // Detect status, read only.
	localparam logic [7:0] APO_ADDR_IF_CTRL = 8'h12; // Interface override, select and power.
	localparam logic [7:0] APO_ADDR_PHASE = 8'h20; // Sampling phase adjustment.
	localparam logic [7:0] APO_ADDR_MODE = 8'h21; // Output channel mode.

	////////////////////////////////////////////////////////////////////////////
	// Field positions inside the registers.
	localparam int APO_BIT_HS_POL = 4; // One drives the sync output active high.
	localparam int APO_BIT_ANA_HI = 7; // Top of the three analog detect bits.
	localparam int APO_ANA_BITS = 3; // Number of analog detect bits.
	localparam int APO_BIT_DIG_CLK = 4; // Digital interface clock detect.
	localparam int APO_BIT_OVERRIDE = 7; // Software chooses the interface.
	localparam int APO_BIT_SELECT = 6; // Zero is analog, one is digital.
	localparam int APO_BIT_POWER = 0; // Zero allows full power down.
	localparam int APO_BIT_DUAL = 0; // One selects dual-channel output.

	////////////////////////////////////////////////////////////////////////////
	// Widths and limits.
	localparam int APO_PHASE_W = 5; // 32 equal steps over one period.
	localparam int APO_RUN_W = 12; // Width of the sync level run counters.
	localparam logic [APO_RUN_W-1:0] APO_RUN_MAX = 12'hFFF; // Run counter saturation.
	localparam logic [7:0] APO_ONE = 8'h01; // First pixel clock of a sync pulse.

	////////////////////////////////////////////////////////////////////////////
	// Software controls, held together.
	typedef struct packed {
		logic hs_pol; // Sync output polarity.
		logic [7:0] hs_width; // Sync output width.
		logic [APO_PHASE_W-1:0] phase; // Sampling phase step.
		logic dual; // Dual-channel mode.
		logic override; // Software selects the interface.
		logic select; // Selected interface when overridden.
		logic power_up; // Zero lets the block power everything down.
	} apo_ctrl_t;

	// Values after reset.
	localparam apo_ctrl_t APO_CTRL_RST = '{
		hs_pol: 1'b1,
		hs_width: 8'h20,
		phase: 5'h00,
		dual: 1'b0,
		override: 1'b0,
		select: 1'b0,
		power_up: 1'b1
	};

	// Outcome of the interface selection.
	typedef struct packed {
		logic analog_act; // Analog interface powered and in use.
		logic digital_act; // Digital interface powered and in use.
		logic sync_det; // Sync detect pin level.
	} apo_ifsel_t;

	// Positions of the inputs inside the synchroniser vector.
	localparam int APO_SYN_HS = 5;
	localparam int APO_SYN_COAST = 4;
	localparam int APO_SYN_DIG = 3;
	localparam int APO_SYN_W = 6;

endpackage : apo_pkg

// File: apo_scaler.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Display scaler model that latches both pixel ports on each rising data clock edge.
module apo_scaler #(
	parameter int PIXEL_W = 8
) (
	input wire logic data_clock,
	input wire logic [PIXEL_W-1:0] port_a,
	input wire logic [PIXEL_W-1:0] port_b,
	input wire logic port_b_oe_n
);
	// Port B as the board sees it; a released bus floats instead of keeping its last value.
	logic [PIXEL_W-1:0] wire_b;
	// Everything latched so far, drained by the bench.
	logic [PIXEL_W-1:0] lat_a[$];
	logic [PIXEL_W-1:0] lat_b[$];

	assign wire_b = port_b_oe_n ? {PIXEL_W{1'bz}} : port_b;

	// The scaler only looks at the ports on the rising clock edge, like real receiving logic.
	// Port B changes in the same time step as that edge, so the latch waits until the outputs settle.
	always @(posedge data_clock) begin
		#1;
		lat_a.push_back(port_a);
		lat_b.push_back(wire_b);
	end
endmodule : apo_scaler

// File: apo_sync.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for asynchronous pin levels.
module apo_sync #(
	parameter int WIDTH = 1
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic [WIDTH-1:0] ASYNC_IN,
	output logic [WIDTH-1:0] SYNC_OUT
);
	import apo_pkg::*;

	// Both stages as one state word; only the second stage is read outside.
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} apo_sync_t;

	apo_sync_t s; // Registered stages.
	apo_sync_t next_s; // Next value of the stages.

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("synchroniser width must be at least one");
		end
	endgenerate

	// The first stage feeds the second and nothing else, to let metastability settle.
	always_comb begin
		next_s = s;
		next_s.first = ASYNC_IN;
		next_s.second = s.first;
	end

	// Both stages clear on reset.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign SYNC_OUT = s.second;

endmodule : apo_sync

// File: apo_top.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Sync leading-edge sample goes to port A
// - Dual mode alternates samples A then B
// - Single mode: port A only, B floats
// - Data clock rises between port A changes
// - Software sets sampling phase, 32 steps
// - Detect sync polarity, output chosen polarity
// - Sync output aligned with clock and data
// - Sync output width set by register
// - Coast blocks sync, holds pixel clock
// - Coast source is the external COAST_IN pin only
// - Digital clock detect status bit provided
// - Override bit lets select bit choose
// - Power-down with nothing detected: all off
// - Override: select zero analog, one digital
module apo_top #(
	parameter int PIXEL_W = 8
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [PIXEL_W-1:0] SAMPLE_IN,
	input wire logic SAMPLE_VALID,
	input wire logic HSYNC_IN,
	input wire logic COAST_IN,
	input wire logic [apo_pkg::APO_ANA_BITS-1:0] ANALOG_DETECT,
	input wire logic DIGITAL_CLOCK_DETECT,
	output logic [PIXEL_W-1:0] PORT_A,
	output logic [PIXEL_W-1:0] PORT_B,
	output logic PORT_B_OE_N,
	output logic OUTPUT_DATA_CLOCK,
	output logic HSYNC_OUTPUT,
	output logic PLL_SYNC,
	output logic PLL_HOLD,
	output logic [apo_pkg::APO_PHASE_W-1:0] SAMPLE_PHASE,
	output logic ANALOG_ACTIVE,
	output logic DIGITAL_ACTIVE,
	output logic SYNC_DETECT_PIN
);
	import apo_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State of the block, held as one word.
	typedef struct packed {
		apo_ctrl_t ctrl; // Software controls.
		logic [7:0] rdata; // Read data, valid the cycle after a read strobe.
		logic [PIXEL_W-1:0] port_a; // Port A data.
		logic [PIXEL_W-1:0] port_b; // Port B data.
		logic b_oe_n; // High floats port B.
		logic dclk; // Output data clock.
		logic next_is_b; // Next ordinary sample belongs to port B.
		logic ref_pending; // Leading edge seen, reference sample not yet taken.
		logic hs_prev; // Previous synchronised sync level.
		logic pol_high; // Incoming sync is active high.
		logic hs_pulse; // Sync output pulse, active high internally.
		logic hs_out; // Sync output pin at its programmed polarity.
		logic [7:0] hs_cnt; // Pixel clocks of the pulse so far.
		logic [APO_RUN_W-1:0] run_cnt; // Length of the present sync level.
		logic [APO_RUN_W-1:0] high_len; // Length of the last high level.
		logic [APO_RUN_W-1:0] low_len; // Length of the last low level.
		logic pll_sync; // Sync pulse toward the clock generator.
		logic pll_hold; // Hold request toward the clock generator.
		apo_ifsel_t ifsel; // Interface selection outcome.
	} apo_state_t;

	apo_state_t s; // Registered state.
	apo_state_t next_s; // Next state.
	logic [APO_SYN_W-1:0] syn; // Synchronised pin levels.
	logic [APO_ANA_BITS-1:0] ana_det; // Synchronised analog detects.
	logic dig_det; // Synchronised digital clock detect.
	logic coast; // Synchronised coast.
	logic hs_now; // Synchronised sync level.
	logic act_now; // Sync in its active sense, this cycle.
	logic act_prev; // Sync in its active sense, last cycle.
	logic lead; // Leading edge of incoming sync.
	logic take_ref; // The next valid sample is the reference.
	logic ana_any; // Any analog detect.

	generate
		if (PIXEL_W < 1) begin : g_bad_width
			$error("pixel width must be at least one");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// The sync, coast and detect pins are asynchronous and pass two flops first.
	apo_sync #(
		.WIDTH(APO_SYN_W)
	) u_sync (
		.CLOCK(CLOCK),
		.SYS_RST(SYS_RST),
		.ASYNC_IN({HSYNC_IN, COAST_IN, DIGITAL_CLOCK_DETECT, ANALOG_DETECT}),
		.SYNC_OUT(syn)
	);

	assign hs_now = syn[APO_SYN_HS];
	assign coast = syn[APO_SYN_COAST];
	assign dig_det = syn[APO_SYN_DIG];
	assign ana_det = syn[APO_ANA_BITS-1:0];
	assign ana_any = |ana_det;
	// The leading edge is the move into the active level, whichever polarity arrives.
	assign act_now = s.pol_high ? hs_now : ~hs_now;
	assign act_prev = s.pol_high ? s.hs_prev : ~s.hs_prev;
	assign lead = act_now & ~act_prev;
	assign take_ref = lead | s.ref_pending;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the registers, the data path, sync and selection.
	always_comb begin
		next_s = s;
		// Register writes come first so the data path and sync output polarity follow them on the same edge.
		if (WR) begin
			case (ADDR)
				APO_ADDR_HS_POL: begin
					next_s.ctrl.hs_pol = WDATA[APO_BIT_HS_POL];
				end
				APO_ADDR_HS_WIDTH: begin
					next_s.ctrl.hs_width = WDATA;
				end
				APO_ADDR_IF_CTRL: begin
					next_s.ctrl.override = WDATA[APO_BIT_OVERRIDE];
					next_s.ctrl.select = WDATA[APO_BIT_SELECT];
					next_s.ctrl.power_up = WDATA[APO_BIT_POWER];
				end
				APO_ADDR_PHASE: begin
					next_s.ctrl.phase = WDATA[APO_PHASE_W-1:0];
				end
				APO_ADDR_MODE: begin
					next_s.ctrl.dual = WDATA[APO_BIT_DUAL];
				end
				default: begin
					// Writes to other addresses are ignored.
				end
			endcase
		end
		// Reads answer in the next cycle; unmapped addresses and reserved bits read zero.
		next_s.rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				APO_ADDR_HS_POL: begin
					next_s.rdata[APO_BIT_HS_POL] = s.ctrl.hs_pol;
				end
				APO_ADDR_HS_WIDTH: begin
					next_s.rdata = s.ctrl.hs_width;
				end
				APO_ADDR_DETECT: begin
					next_s.rdata[APO_BIT_ANA_HI -: APO_ANA_BITS] = ana_det;
					next_s.rdata[APO_BIT_DIG_CLK] = dig_det;
				end
				APO_ADDR_IF_CTRL: begin
					next_s.rdata[APO_BIT_OVERRIDE] = s.ctrl.override;
					next_s.rdata[APO_BIT_SELECT] = s.ctrl.select;
					next_s.rdata[APO_BIT_POWER] = s.ctrl.power_up;
				end
				APO_ADDR_PHASE: begin
					next_s.rdata[APO_PHASE_W-1:0] = s.ctrl.phase;
				end
				APO_ADDR_MODE: begin
					next_s.rdata[APO_BIT_DUAL] = s.ctrl.dual;
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end

		// Polarity: the active level is the shorter of the two, since sync is a narrow pulse.
		next_s.hs_prev = hs_now;
		if (hs_now != s.hs_prev) begin
			if (s.hs_prev) begin
				next_s.high_len = s.run_cnt;
			end else begin
				next_s.low_len = s.run_cnt;
			end
			next_s.run_cnt = {{(APO_RUN_W-1){1'b0}}, 1'b1};
		end else if (s.run_cnt != APO_RUN_MAX) begin
			next_s.run_cnt = s.run_cnt + 1'b1;
		end
		next_s.pol_high = (s.high_len < s.low_len);

		// Coast gates the clock generator's sync and asks it to hold its frequency.
		next_s.pll_sync = lead & ~coast;
		next_s.pll_hold = coast;

		// Data path. A leading edge waits for its sample if none comes in the same cycle.
		if (lead) begin
			next_s.ref_pending = 1'b1;
		end
		if (SAMPLE_VALID) begin
			if (take_ref || !s.next_is_b || !next_s.ctrl.dual) begin
				next_s.port_a = SAMPLE_IN;
				next_s.dclk = 1'b0;
				next_s.next_is_b = next_s.ctrl.dual;
			end else begin
				next_s.port_b = SAMPLE_IN;
				next_s.dclk = 1'b1;
				next_s.next_is_b = 1'b0;
			end
			if (take_ref) begin
				// A new line restarts the alternation and the sync pulse.
				next_s.ref_pending = 1'b0;
				next_s.hs_pulse = 1'b1;
				next_s.hs_cnt = APO_ONE;
			end else if (s.hs_pulse) begin
				if (s.hs_cnt >= s.ctrl.hs_width) begin
					next_s.hs_pulse = 1'b0;
				end else begin
					next_s.hs_cnt = s.hs_cnt + 1'b1;
				end
			end
		end else if (!next_s.ctrl.dual) begin
			// Single mode: the clock rises in the gap after each port A change.
			next_s.dclk = 1'b1;
		end
		// Port B floats and reads zero in single mode.
		if (!next_s.ctrl.dual) begin
			next_s.port_b = '0;
			next_s.next_is_b = 1'b0;
		end
		next_s.b_oe_n = ~next_s.ctrl.dual;
		// The pin leaves from the same edge as the data and the clock.
		next_s.hs_out = next_s.hs_pulse ~^ next_s.ctrl.hs_pol;

		// Interface selection from the present controls and detects.
		next_s.ifsel = '0;
		if (!s.ctrl.power_up && !ana_any && !dig_det) begin
			next_s.ifsel = '0;
		end else if (s.ctrl.override) begin
			next_s.ifsel.analog_act = ~s.ctrl.select;
			next_s.ifsel.digital_act = s.ctrl.select;
		end else if (ana_any) begin
			next_s.ifsel.analog_act = 1'b1;
		end else if (dig_det) begin
			next_s.ifsel.digital_act = 1'b1;
		end
		next_s.ifsel.sync_det = (ana_any | dig_det) & (next_s.ifsel.analog_act | next_s.ifsel.digital_act);
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; reset loads constants only.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			s <= '0;
			s.ctrl <= APO_CTRL_RST;
			s.low_len <= APO_RUN_MAX;
			s.pol_high <= 1'b1;
			s.b_oe_n <= 1'b1;
			s.dclk <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Every output is a state flop.
	assign RDATA = s.rdata;
	assign PORT_A = s.port_a;
	assign PORT_B = s.port_b;
	assign PORT_B_OE_N = s.b_oe_n;
	assign OUTPUT_DATA_CLOCK = s.dclk;
	assign HSYNC_OUTPUT = s.hs_out;
	assign PLL_SYNC = s.pll_sync;
	assign PLL_HOLD = s.pll_hold;
	assign SAMPLE_PHASE = s.ctrl.phase;
	assign ANALOG_ACTIVE = s.ifsel.analog_act;
	assign DIGITAL_ACTIVE = s.ifsel.digital_act;
	assign SYNC_DETECT_PIN = s.ifsel.sync_det;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the behaviour.
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);

	// Reference sample accepted with no register write under way.
	sequence s_ref_taken;
		SAMPLE_VALID && take_ref && s.ctrl.dual && !WR;
	endsequence

	// The following ordinary sample.
	sequence s_next_plain;
		SAMPLE_VALID && !lead && !WR;
	endsequence

	property p_ref_on_a;
		SAMPLE_VALID && take_ref |=> PORT_A == $past(SAMPLE_IN) && s.hs_pulse && s.hs_cnt == APO_ONE;
	endproperty
	a_ref_on_a: assert property (p_ref_on_a) else $error("reference sample not on port A");

	property p_b_after_ref;
		s_ref_taken ##1 s_next_plain |=> PORT_B == $past(SAMPLE_IN) && OUTPUT_DATA_CLOCK;
	endproperty
	a_b_after_ref: assert property (p_b_after_ref) else $error("sample after reference not on port B");

	property p_single_float;
		!s.ctrl.dual && !WR |=> PORT_B_OE_N && PORT_B == '0 && $stable(PORT_B_OE_N);
	endproperty
	a_single_float: assert property (p_single_float) else $error("port B driven in single mode");

	property p_clock_between;
		$rose(OUTPUT_DATA_CLOCK) |-> $stable(PORT_A);
	endproperty
	a_clock_between: assert property (p_clock_between) else $error("data clock rose with port A change");

	property p_phase_write;
		WR && ADDR == APO_ADDR_PHASE |=> SAMPLE_PHASE == $past(WDATA[APO_PHASE_W-1:0]);
	endproperty
	a_phase_write: assert property (p_phase_write) else $error("phase write not applied");

	property p_polarity;
		SAMPLE_VALID && take_ref && !WR |=> HSYNC_OUTPUT == s.ctrl.hs_pol ##1 (s.hs_pulse -> HSYNC_OUTPUT == s.ctrl.hs_pol);
	endproperty
	a_polarity: assert property (p_polarity) else $error("sync output at wrong polarity");

	property p_width_end;
		SAMPLE_VALID && !take_ref && s.hs_pulse && s.hs_cnt >= s.ctrl.hs_width |=> !s.hs_pulse;
	endproperty
	a_width_end: assert property (p_width_end) else $error("sync pulse overran its width");

	property p_width_hold;
		SAMPLE_VALID && !take_ref && s.hs_pulse && s.hs_cnt < s.ctrl.hs_width |=> s.hs_pulse && s.hs_cnt == $past(s.hs_cnt) + 8'h01;
	endproperty
	a_width_hold: assert property (p_width_hold) else $error("sync pulse ended early");

	property p_coast;
		coast |=> !PLL_SYNC && PLL_HOLD;
	endproperty
	a_coast: assert property (p_coast) else $error("sync reached clock generator during coast");

	property p_override;
		s.ctrl.override && s.ctrl.power_up |=> DIGITAL_ACTIVE == $past(s.ctrl.select) && ANALOG_ACTIVE != DIGITAL_ACTIVE;
	endproperty
	a_override: assert property (p_override) else $error("override select not followed");

	property p_power_down;
		!s.ctrl.power_up && !ana_any && !dig_det |=> !ANALOG_ACTIVE && !DIGITAL_ACTIVE && !SYNC_DETECT_PIN;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power down left something active");

	property p_status_read;
		RD && ADDR == APO_ADDR_DETECT |=> RDATA[APO_BIT_DIG_CLK] == $past(dig_det) ##1 RDATA == 8'h00 || $past(RD);
	endproperty
	a_status_read: assert property (p_status_read) else $error("detect status read wrong");

endmodule : apo_top

// File: apo_top_tb.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the pixel output and interface select block.
module apo_top_tb;
	import apo_pkg::*;
	localparam int PW = 8; // Pixel width used here.
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [PW-1:0] sample_in = '0;
	logic sample_valid = 1'b0;
	logic hsync_in = 1'b0;
	logic coast_in = 1'b0; // Left low on every line so the clock generator follows the sync.
	logic [2:0] analog_detect = 3'h0;
	logic digital_clock_detect = 1'b0;
	wire logic [7:0] rdata;
	wire logic [PW-1:0] port_a;
	wire logic [PW-1:0] port_b;
	wire logic port_b_oe_n;
	wire logic data_clock;
	wire logic hsync_output;
	wire logic pll_sync;
	wire logic pll_hold;
	wire logic [APO_PHASE_W-1:0] sample_phase;
	wire logic analog_active;
	wire logic digital_active;
	wire logic sync_detect_pin;
	int n_mismatch = 0; // Mismatches seen.
	int checks = 0; // Comparisons made.
	int cycles = 0; // Watchdog count.
	logic pol_cur = 1'b1; // Programmed sync output polarity.
	int hs_cnt = 0; // Cycles with the sync output active.
	int ps_cnt = 0; // Pulses towards the clock generator.
	logic hs_prev = 1'b0;
	logic [PW-1:0] first_a = '0; // Port A when the sync output went active.

	apo_top #(.PIXEL_W(PW)) uut (.CLOCK(clock), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .SAMPLE_IN(sample_in), .SAMPLE_VALID(sample_valid), .HSYNC_IN(hsync_in),
		.COAST_IN(coast_in), .ANALOG_DETECT(analog_detect), .DIGITAL_CLOCK_DETECT(digital_clock_detect),
		.PORT_A(port_a), .PORT_B(port_b), .PORT_B_OE_N(port_b_oe_n), .OUTPUT_DATA_CLOCK(data_clock),
		.HSYNC_OUTPUT(hsync_output), .PLL_SYNC(pll_sync), .PLL_HOLD(pll_hold), .SAMPLE_PHASE(sample_phase),
		.ANALOG_ACTIVE(analog_active), .DIGITAL_ACTIVE(digital_active), .SYNC_DETECT_PIN(sync_detect_pin));

	apo_scaler #(.PIXEL_W(PW)) partner (.data_clock(data_clock), .port_a(port_a), .port_b(port_b),
		.port_b_oe_n(port_b_oe_n));

	////////////////////////////////////////////////////////////////////////////
	// Clock at 100 MHz.
	initial begin
		forever #5 clock = ~clock;
	end

	// Watchdog; the whole run needs under five hundred cycles.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	// Monitor sampled after the edge has settled, so no race with the design.
	always @(posedge clock) begin
		#1;
		if (hsync_output === pol_cur) begin
			hs_cnt++;
			if (!hs_prev) begin
				first_a = port_a;
			end
		end
		hs_prev = (hsync_output === pol_cur);
		if (pll_sync === 1'b1) begin
			ps_cnt++;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare one value; four-state so an unknown matches only the same unknown expected.
	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		checks++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : chk

	task automatic wrap_up();
		if (n_mismatch == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	// One-cycle write strobe.
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : reg_write

	// One-cycle read strobe; data is looked at only in the following cycle.
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_read

	// Expected interface selection as {analog, digital, sync detect}.
	function automatic logic [2:0] exp_sel(input logic [2:0] c, input logic [2:0] ana, input logic dig);
		logic any_a;
		logic a;
		logic d;
		any_a = |ana;
		a = 1'b0;
		d = 1'b0;
		// Power bit low with nothing detected leaves both interfaces off.
		if (c[0] || any_a || dig) begin
			if (c[2]) begin
				a = !c[1];
				d = c[1];
			end else if (any_a) begin
				a = 1'b1;
			end else if (dig) begin
				d = 1'b1;
			end
		end
		return {a, d, (any_a || dig) && (a || d)};
	endfunction : exp_sel

	// Sync pin pulse short enough that the high level is taken as the active one.
	task automatic hs_pulse();
		@(posedge clock);
		hsync_in <= 1'b1;
		repeat (4) @(posedge clock);
		hsync_in <= 1'b0;
	endtask : hs_pulse

	// One line of n samples; single mode leaves an idle cycle after each sample.
	task automatic run_line(input logic dual, input int n, input logic [7:0] w, input logic pol);
		logic [PW-1:0] s[$];
		logic [PW-1:0] v;
		reg_write(APO_ADDR_MODE, {7'h00, dual});
		reg_write(APO_ADDR_HS_WIDTH, w);
		reg_write(APO_ADDR_HS_POL, {3'h0, pol, 4'h0});
		pol_cur = pol;
		repeat (3) @(posedge clock);
		partner.lat_a.delete();
		partner.lat_b.delete();
		hs_cnt = 0;
		hs_pulse();
		for (int k = 0; k < n; k++) begin
			v = PW'($urandom);
			s.push_back(v);
			sample_in <= v;
			sample_valid <= 1'b1;
			@(posedge clock);
			if (!dual) begin
				sample_valid <= 1'b0;
				@(posedge clock);
			end
		end
		sample_valid <= 1'b0;
		repeat (4) @(posedge clock);
		#1 chk(first_a, s[0]);
		chk(hsync_output, !pol);
		if (dual) begin
			chk(hs_cnt, w);
			chk(partner.lat_a.size(), n / 2);
			for (int i = 0; i < n / 2; i++) begin
				chk(partner.lat_a[i], s[2 * i]);
				chk(partner.lat_b[i], s[2 * i + 1]);
			end
		end else begin
			chk(port_b_oe_n, 1'b1);
			chk(partner.lat_a.size(), n);
			for (int i = 0; i < n; i++) begin
				chk(partner.lat_a[i], s[i]);
				chk(partner.lat_b[i], {PW{1'bz}});
			end
		end
	endtask : run_line

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic [7:0] d;
		logic [7:0] ra[6];
		logic [7:0] re[6];
		logic [2:0] c;
		logic [2:0] ana;
		logic dig;
		logic [4:0] ph;
		void'($urandom(38098));
		ra = '{APO_ADDR_HS_POL, APO_ADDR_HS_WIDTH, APO_ADDR_IF_CTRL, APO_ADDR_PHASE, APO_ADDR_MODE, 8'h30};
		re = '{8'h10, 8'h20, 8'h01, 8'h00, 8'h00, 8'h00};
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		#1 chk(port_b_oe_n, 1'b1);
		// Reset values, then an unmapped place that must ignore writes.
		reg_write(8'h30, 8'hA5);
		for (int i = 0; i < 6; i++) begin
			reg_read(ra[i], d);
			chk(d, re[i]);
		end
		// Phase steps at both ends of the range and one at random.
		for (int i = 0; i < 3; i++) begin
			ph = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : 5'($urandom);
			reg_write(APO_ADDR_PHASE, {3'h0, ph});
			@(posedge clock);
			#1 chk(sample_phase, ph);
		end
		// Lines in both modes; the odd one leaves alternation half done before the next line.
		run_line(1'b0, 6, 8'h03, 1'b1);
		run_line(1'b1, 8, 8'($urandom_range(4, 1)), 1'b1);
		run_line(1'b1, 5, 8'($urandom_range(4, 1)), 1'b0);
		run_line(1'b1, 8, 8'($urandom_range(4, 1)), 1'b1);
		// Coast holds the clock generator and swallows the sync pulse.
		@(posedge clock);
		coast_in <= 1'b1;
		repeat (4) @(posedge clock);
		#1 chk(pll_hold, 1'b1);
		ps_cnt = 0;
		hs_pulse();
		repeat (8) @(posedge clock);
		chk(ps_cnt, 0);
		coast_in <= 1'b0;
		repeat (4) @(posedge clock);
		#1 chk(pll_hold, 1'b0);
		ps_cnt = 0;
		hs_pulse();
		repeat (8) @(posedge clock);
		chk(ps_cnt, 1);
		// Active-low sync: long high levels with short low pulses flip the detected polarity.
		hsync_in <= 1'b1;
		repeat (40) @(posedge clock);
		repeat (2) begin
			hsync_in <= 1'b0;
			repeat (4) @(posedge clock);
			hsync_in <= 1'b1;
			repeat (40) @(posedge clock);
		end
		ps_cnt = 0;
		hsync_in <= 1'b0;
		repeat (8) @(posedge clock);
		chk(ps_cnt, 1);
		// Interface selection; the block ORs the analog bits and settles priority itself.
		for (int i = 0; i < 14; i++) begin
			@(posedge clock);
			c = 3'($urandom);
			ana = 3'($urandom);
			dig = 1'($urandom);
			if (i == 0) begin
				c = 3'b000;
				ana = 3'h0;
				dig = 1'b0;
			end else if (i < 3) begin
				c = (i == 1) ? 3'b101 : 3'b111;
				ana = 3'h2;
				dig = 1'b1;
			end
			analog_detect <= ana;
			digital_clock_detect <= dig;
			reg_write(APO_ADDR_IF_CTRL, {c[2], c[1], 5'h00, c[0]});
			reg_write(APO_ADDR_DETECT, 8'hFF);
			repeat (5) @(posedge clock);
			#1 chk({analog_active, digital_active, sync_detect_pin}, exp_sel(c, ana, dig));
			reg_read(APO_ADDR_DETECT, d);
			chk(d, {ana, dig, 4'h0});
		end
		wrap_up();
	end
endmodule : apo_top_tb
